// file: rtl/result_output_port.sv
// Result output port of a 16-bit sampling converter: parallel byte bus,
// serial shifter with external or internal shift clock, busy flag.
// Assumes host pins are asynchronous; raw results come from the core.
// Function
// - high format select means straight binary
// - external mode shifts on host clock
// - internal mode: convert sends previous result
// - byte select high low byte, else high
// - drive bus only chip select low, read high
// - top pins follow byte select; may float
// - chip select fall with read low converts
// - busy low from start until result enters buffer
// - internal mode 16 pulses then clock low
`timescale 1ns/100ps
`default_nettype none
module result_output_port
    import result_port_pkg::*;
#(
    parameter int unsigned CONV_CYCLES = CONV_CYC,
    parameter int unsigned HALF_CYCLES = HALF_BIT_CYC
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic [RESULT_W-1:0] core_result,
    input  wire logic                chip_sel_n,
    input  wire logic                read_conv,
    input  wire logic                byte_sel,
    input  wire logic                code_format_sel,
    input  wire logic                clock_source_sel,
    input  wire logic                shift_clk_in,
    output logic                     serial_shift_clock,
    output logic                     serial_shift_clock_oe,
    output logic                     serial_out,
    output logic [BYTE_W-1:0]        par_data,
    output logic [BYTE_W-1:0]        par_oe,
    output logic                     busy_n,
    output logic                     sample_valid,
    input  wire logic                sample_ready,
    output logic [RESULT_W-1:0]      sample_data
);
    import result_port_pkg::*;

    // =========================================================
    // Input synchronisers
    host_pins_type    meta_q;
    host_pins_type    sync_q;
    logic             conv_req_q;
    logic             ext_clk_d1_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= '{chip_sel_n: 1'b1, read_conv: 1'b1, default: 1'b0};
            sync_q <= '{chip_sel_n: 1'b1, read_conv: 1'b1, default: 1'b0};
        end else begin
            meta_q <= '{chip_sel_n, read_conv, byte_sel, code_format_sel,
                        clock_source_sel, shift_clk_in};
            sync_q <= meta_q;
        end
    end

    // OR of chip select and read: falling edge starts a conversion
    logic conv_or;
    logic conv_start;
    assign conv_or    = sync_q.chip_sel_n | sync_q.read_conv;
    assign conv_start = conv_req_q && !conv_or;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            conv_req_q   <= 1'b1;
            ext_clk_d1_q <= 1'b0;
        end else begin
            conv_req_q   <= conv_or;
            ext_clk_d1_q <= sync_q.ext_clk;
        end
    end

    // =========================================================
    // Conversion timer and busy flag
    logic [$clog2(CONV_CYCLES+1)-1:0] conv_cnt_q;
    logic                             busy_q;
    logic                             conv_done;
    assign conv_done = busy_q && (conv_cnt_q == '0);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy_q     <= 1'b0;
            conv_cnt_q <= '0;
        end else if (conv_start && !busy_q) begin
            busy_q     <= 1'b1;
            conv_cnt_q <= ($clog2(CONV_CYCLES+1))'(CONV_CYCLES - 1);
        end else if (conv_done) begin
            busy_q     <= 1'b0;
        end else if (busy_q) begin
            conv_cnt_q <= conv_cnt_q - 1'b1;
        end
    end
    assign busy_n = !busy_q;

    // =========================================================
    // Result buffer between core and output register
    logic [RESULT_W-1:0] fifo_data;
    logic                fifo_valid;
    logic                fifo_in_ready;
    logic                fifo_pop;

    result_fifo #(
        .WIDTH (RESULT_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_data   (core_result),
        .in_valid  (conv_done),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    // Output register takes the oldest result when the shifter is idle
    // and the stream consumer has room, so no held sample is overwritten
    ser_state_type       ser_q;
    logic [RESULT_W-1:0] out_q;
    logic [RESULT_W-1:0] shift_q;
    logic [4:0]          bit_cnt_q;
    logic                hold_q;
    assign fifo_pop = fifo_valid && (ser_q == SER_IDLE) && !conv_start
                      && (!hold_q || sample_ready);

    // Coding: straight binary, or twos complement via MSB flip
    logic [RESULT_W-1:0] coded;
    assign coded = sync_q.code_format_sel ? fifo_data : (fifo_data ^ SIGN_FLIP);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_q <= RESULT_RESET;
        end else if (fifo_pop) begin
            out_q <= coded;
        end
    end

    // Sample stream copy for on-chip consumers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hold_q      <= 1'b0;
            sample_data <= RESULT_RESET;
        end else if (fifo_pop) begin
            hold_q      <= 1'b1;
            sample_data <= coded;
        end else if (sample_ready) begin
            hold_q      <= 1'b0;
        end
    end
    assign sample_valid = hold_q;

    // =========================================================
    // Parallel bus
    logic par_en;
    assign par_en = !sync_q.chip_sel_n && sync_q.read_conv;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            par_data <= '0;
        end else begin
            par_data <= sync_q.byte_sel ? out_q[BYTE_W-1:0]
                                        : out_q[RESULT_W-1:BYTE_W];
        end
    end
    assign par_oe = {BYTE_W{par_en}};

    // =========================================================
    // Serial shifter
    logic [$clog2(HALF_CYCLES+1)-1:0] half_q;
    logic                             int_clk_q;
    logic                             ext_rise;
    assign ext_rise = sync_q.ext_clk && !ext_clk_d1_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ser_q     <= SER_IDLE;
            shift_q   <= RESULT_RESET;
            bit_cnt_q <= '0;
            half_q    <= '0;
            int_clk_q <= 1'b0;
        end else begin
            unique case (ser_q)
                SER_IDLE: begin
                    int_clk_q <= 1'b0;
                    if (sync_q.clock_source_sel) begin
                        if (par_en && ext_rise) begin
                            shift_q <= {shift_q[RESULT_W-2:0], 1'b0};
                        end else if (!par_en) begin
                            shift_q <= out_q;
                        end
                    end else if (conv_start) begin
                        shift_q   <= out_q;
                        bit_cnt_q <= 5'(SERIAL_PULSES);
                        half_q    <= ($clog2(HALF_CYCLES+1))'(HALF_CYCLES - 1);
                        ser_q     <= SER_LOW;
                    end
                end
                SER_LOW: begin
                    if (half_q == '0) begin
                        int_clk_q <= 1'b1;
                        half_q    <= ($clog2(HALF_CYCLES+1))'(HALF_CYCLES - 1);
                        ser_q     <= SER_HIGH;
                    end else begin
                        half_q <= half_q - 1'b1;
                    end
                end
                SER_HIGH: begin
                    if (half_q == '0) begin
                        int_clk_q <= 1'b0;
                        half_q    <= ($clog2(HALF_CYCLES+1))'(HALF_CYCLES - 1);
                        shift_q   <= {shift_q[RESULT_W-2:0], 1'b0};
                        bit_cnt_q <= bit_cnt_q - 1'b1;
                        ser_q     <= (bit_cnt_q == 5'd1) ? SER_IDLE : SER_LOW;
                    end else begin
                        half_q <= half_q - 1'b1;
                    end
                end
                default: ser_q <= SER_IDLE;
            endcase
        end
    end

    assign serial_shift_clock    = int_clk_q;
    assign serial_shift_clock_oe = !sync_q.clock_source_sel;
    assign serial_out            = shift_q[RESULT_W-1];

    // Busy length count for the duration check
    logic [$clog2(CONV_CYCLES+1)-1:0] busy_len_q;
    always_ff @(posedge clk) begin
        if (!rst_n || !busy_q) begin
            busy_len_q <= '0;
        end else begin
            busy_len_q <= busy_len_q + 1'b1;
        end
    end

    // =========================================================
    // Checks
    sequence s_conv_begin;
        conv_start && !busy_q;
    endsequence

    a_busy_fall: assert property (@(posedge clk) disable iff (!rst_n)
        s_conv_begin |=> !busy_n)
        else $error("busy did not assert on conversion start");
    a_busy_hold: assert property (@(posedge clk) disable iff (!rst_n)
        conv_done |-> (busy_len_q == (CONV_CYCLES - 1)))
        else $error("busy released too early");
    a_par_float: assert property (@(posedge clk) disable iff (!rst_n)
        (sync_q.chip_sel_n || !sync_q.read_conv) |-> par_oe == '0)
        else $error("parallel bus driven while deselected");
    a_par_drive: assert property (@(posedge clk) disable iff (!rst_n)
        (!sync_q.chip_sel_n && sync_q.read_conv) |-> par_oe == 8'hFF)
        else $error("parallel bus not driven while selected");
    a_byte_low: assert property (@(posedge clk) disable iff (!rst_n)
        (sync_q.byte_sel && $stable(out_q)) |=> par_data == $past(out_q[7:0]))
        else $error("low byte wrong");
    a_byte_high: assert property (@(posedge clk) disable iff (!rst_n)
        (!sync_q.byte_sel && $stable(out_q)) |=> par_data == $past(out_q[15:8]))
        else $error("high byte wrong");
    a_code_fmt: assert property (@(posedge clk) disable iff (!rst_n)
        fifo_pop |=> out_q == ($past(sync_q.code_format_sel) ? $past(fifo_data)
                                                      : ($past(fifo_data) ^ 16'h8000)))
        else $error("output coding wrong");
    a_result_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !fifo_pop |=> $stable(out_q))
        else $error("result changed without new conversion");
    a_int_start: assert property (@(posedge clk) disable iff (!rst_n)
        (ser_q == SER_IDLE && !sync_q.clock_source_sel && conv_start)
        |=> ser_q == SER_LOW && bit_cnt_q == 5'd16)
        else $error("internal transfer did not start");
    a_clk_idle: assert property (@(posedge clk) disable iff (!rst_n)
        (ser_q == SER_IDLE) |=> (ser_q == SER_IDLE) |-> !serial_shift_clock)
        else $error("shift clock not low between transfers");
    a_ext_dir: assert property (@(posedge clk) disable iff (!rst_n)
        sync_q.clock_source_sel |-> !serial_shift_clock_oe)
        else $error("shift clock driven in external mode");
endmodule
`default_nettype wire

// file: inc/result_port_pkg.sv
// Shared constants and carrier types for the conversion result output port.
// Assumes a single 200 MHz clock domain inside the device.
package result_port_pkg;
    // =========================================================
    // Widths and counts
    localparam int unsigned RESULT_W       = 16;
    localparam int unsigned BYTE_W         = 8;
    localparam int unsigned SERIAL_PULSES  = 16;
    localparam int unsigned FIFO_DEPTH     = 8;
    // =========================================================
    // Timing
    localparam int unsigned CLK_PERIOD_PS  = 5000;
    localparam int unsigned HALF_BIT_PS    = 40000;   // internal shift clock half period
    localparam int unsigned HALF_BIT_CYC   = (HALF_BIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned CONV_TIME_PS   = 200000;  // conversion duration
    localparam int unsigned CONV_CYC       = (CONV_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [RESULT_W-1:0] RESULT_RESET = 16'h0000;
    localparam logic [RESULT_W-1:0] SIGN_FLIP    = 16'h8000;

    // Host control pins after synchronisation
    typedef struct packed {
        logic chip_sel_n;
        logic read_conv;
        logic byte_sel;
        logic code_format_sel;
        logic clock_source_sel;
        logic ext_clk;
    } host_pins_type;

    // Parallel data pin group
    typedef struct packed {
        logic [BYTE_W-1:0] data;
        logic [BYTE_W-1:0] oe;
    } par_bus_type;

    // Serial state
    typedef enum logic [1:0] {
        SER_IDLE  = 2'b00,
        SER_HIGH  = 2'b01,
        SER_LOW   = 2'b10
    } ser_state_type;
endpackage

// file: rtl/result_fifo.sv
// Small synchronous FIFO for conversion results.
// Assumes one clock; both sides handshake with valid and ready.
`timescale 1ns/100ps
`default_nettype none
module result_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    // Handshake terms
    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_q[rd_q];

    // Storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// file: tb/host_far_end.sv
// Host side model: drives the shift clock in external mode, resolves pins.
// Assumes the bench raises ext_run to ask for one 16-pulse frame.
`timescale 1ns/100ps
`default_nettype none
module host_far_end (
    input  wire logic       ext_run,
    input  wire logic       dev_clk,
    input  wire logic       dev_clk_oe,
    input  wire logic [7:0] par_data,
    input  wire logic [7:0] par_oe,
    output logic            clk_wire,
    output logic [7:0]      par_wire
);
    logic       host_clk;
    logic [7:0] last_lvl;
    // =========================================================
    // Host clock: 16 pulses a frame, still between frames
    initial begin
        host_clk = 1'b0;
        last_lvl = 8'h00;
        forever begin
            wait (ext_run);
            #13;
            repeat (16) begin
                host_clk = 1'b1;
                #80;
                host_clk = 1'b0;
                #80;
            end
            wait (!ext_run);
        end
    end
    // Shared clock pin level from both drivers
    assign clk_wire = dev_clk_oe ? dev_clk : host_clk;
    // Remember last driven level of each data pin
    always @(par_data, par_oe) begin
        for (int i = 0; i < 8; i++) begin
            if (par_oe[i]) last_lvl[i] = par_data[i];
        end
    end
    // Released pins float: show inverse of last level
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            par_wire[i] = par_oe[i] ? par_data[i] : ~last_lvl[i];
        end
    end
endmodule
`default_nettype wire

// file: tb/adc_result_output_port_bench.sv
// Self-checking bench for the result output port.
// Assumes the host model file and the design package are compiled first.
`timescale 1ns/100ps
`default_nettype none
module adc_result_output_port_bench;
    import result_port_pkg::*;
    localparam int CONVC = 4;
    localparam int HALFC = 2;
    logic clk, rst_n, chip_sel_n, read_conv, byte_sel, code_format_sel;
    logic clock_source_sel, sample_ready, ext_run, ssc, ssc_oe, serial_out;
    logic busy_n, sample_valid, clk_wire, sc_prev;
    logic [15:0] core_result, sample_data, last_q, int_bits, ext_bits;
    logic [7:0]  par_data, par_oe, par_wire;
    logic [15:0] got_q[$];
    int num_errors = 0, tests_run = 0, int_cnt = 0, ext_cnt = 0;
    // =========================================================
    // Design, host model and clock
    result_output_port #(.CONV_CYCLES(CONVC), .HALF_CYCLES(HALFC)) u_dut (
        .clk(clk), .rst_n(rst_n), .core_result(core_result), .chip_sel_n(chip_sel_n),
        .read_conv(read_conv), .byte_sel(byte_sel), .code_format_sel(code_format_sel),
        .clock_source_sel(clock_source_sel), .shift_clk_in(clk_wire),
        .serial_shift_clock(ssc), .serial_shift_clock_oe(ssc_oe), .serial_out(serial_out),
        .par_data(par_data), .par_oe(par_oe), .busy_n(busy_n), .sample_valid(sample_valid),
        .sample_ready(sample_ready), .sample_data(sample_data));
    host_far_end u_host (.ext_run(ext_run), .dev_clk(ssc), .dev_clk_oe(ssc_oe),
        .par_data(par_data), .par_oe(par_oe), .clk_wire(clk_wire), .par_wire(par_wire));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Collect internal serial bits, accepted samples and host-clocked bits
    always @(posedge clk) begin
        sc_prev <= ssc;
        if (!sc_prev && ssc) begin
            int_bits <= {int_bits[14:0], serial_out};
            int_cnt <= int_cnt + 1;
        end
        if (sample_valid && sample_ready) got_q.push_back(sample_data);
    end
    always @(posedge clk_wire) if (!ssc_oe) begin
        ext_bits = {ext_bits[14:0], serial_out};
        ext_cnt++;
    end
    // =========================================================
    // Compare and closing tasks
    task automatic check_flag(input logic got, input logic exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // =========================================================
    // Scenarios
    task automatic convert(input logic [15:0] v, input logic fmt, input logic via_rc);
        int n;
        int w;
        @(negedge clk);
        core_result = v;
        code_format_sel = fmt;
        if (via_rc) begin
            read_conv = 1'b1;
            @(negedge clk);
            chip_sel_n = 1'b0;
            @(negedge clk);
            read_conv = 1'b0;
        end else chip_sel_n = 1'b0;
        w = 0;
        while (busy_n !== 1'b0 && w < 10) begin
            @(negedge clk);
            w++;
        end
        check_flag(busy_n, 1'b0, "busy start");
        check_word({8'h00, par_oe}, 16'h0000, "bus off while converting");
        n = 0;
        while (busy_n === 1'b0 && n < 50) begin
            @(negedge clk);
            n++;
        end
        check_word(16'(n), 16'(CONVC), "busy length");
        chip_sel_n = 1'b1;
        read_conv = 1'b0;
        repeat (4) @(negedge clk);
        last_q = fmt ? v : v ^ SIGN_FLIP;
    endtask
    task automatic check_stream(input logic [15:0] exp);
        int w;
        w = 0;
        while (got_q.size() == 0 && w < 20) begin
            @(negedge clk);
            w++;
        end
        check_word((got_q.size() > 0) ? got_q.pop_front() : 16'hDEAD, exp, "sample");
    endtask
    task automatic read_par(input logic [15:0] exp);
        @(negedge clk);
        read_conv = 1'b1;
        @(negedge clk);
        chip_sel_n = 1'b0;
        byte_sel = 1'b1;
        repeat (5) @(negedge clk);
        check_word({8'h00, par_oe}, 16'h00FF, "bus on");
        check_word({8'h00, par_wire}, {8'h00, exp[7:0]}, "low byte");
        byte_sel = 1'b0;
        repeat (5) @(negedge clk);
        check_word({8'h00, par_wire}, {8'h00, exp[15:8]}, "high byte");
        check_flag(par_wire[3], exp[11], "middle pin");
        chip_sel_n = 1'b1;
        repeat (5) @(negedge clk);
        check_word({8'h00, par_oe}, 16'h0000, "bus off");
        read_conv = 1'b0;
    endtask
    task automatic ext_read(input logic [15:0] exp);
        int w;
        @(negedge clk);
        read_conv = 1'b1;
        @(negedge clk);
        chip_sel_n = 1'b0;
        repeat (5) @(negedge clk);
        ext_cnt = 0;
        ext_run = 1'b1;
        w = 0;
        while (ext_cnt < 16 && w < 1000) begin
            @(negedge clk);
            w++;
        end
        check_word(ext_bits, exp, "host clocked bits");
        check_flag(ssc_oe, 1'b0, "clock pin released");
        ext_run = 1'b0;
        chip_sel_n = 1'b1;
        read_conv = 1'b0;
    endtask
    task automatic int_frame(input logic [15:0] v);
        logic [15:0] prev;
        int w;
        clock_source_sel = 1'b0;
        repeat (5) @(negedge clk);
        check_flag(ssc_oe, 1'b1, "clock pin driven");
        prev = last_q;
        int_cnt = 0;
        convert(v, 1'b1, 1'b0);
        w = 0;
        while (int_cnt < 16 && w < 300) begin
            @(negedge clk);
            w++;
        end
        repeat (2 * HALFC + 4) @(negedge clk);
        check_word(16'(int_cnt), 16'd16, "pulse count");
        check_flag(ssc, 1'b0, "clock low after frame");
        check_word(int_bits, prev, "previous result sent");
        clock_source_sel = 1'b1;
    endtask
    // =========================================================
    // Main sequence and watchdog
    initial begin
        rst_n = 1'b0;
        {chip_sel_n, read_conv, byte_sel, code_format_sel} = 4'b1011;
        clock_source_sel = 1'b1;
        sample_ready = 1'b1;
        ext_run = 1'b0;
        core_result = 16'h0000;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        check_flag(busy_n, 1'b1, "reset busy");
        check_word({par_oe, par_data}, 16'h0000, "reset bus");
        check_flag(sample_valid | ssc, 1'b0, "reset stream and clock");
        repeat (4) @(negedge clk);
        convert(16'h1234, 1'b1, 1'b0);
        check_stream(16'h1234);
        read_par(last_q);
        convert(16'hA5C3, 1'b0, 1'b1);
        check_stream(16'h25C3);
        read_par(last_q);
        ext_read(last_q);
        int_frame(16'h0F0F);
        check_stream(16'h0F0F);
        sample_ready = 1'b0;
        convert(16'h8001, 1'b1, 1'b0);
        convert(16'h7FFE, 1'b0, 1'b0);
        check_flag(sample_valid, 1'b1, "sample waiting");
        @(negedge clk);
        sample_ready = 1'b1;
        check_stream(16'h8001);
        check_stream(16'hFFFE);
        wrap_up();
    end
    initial begin
        #100000;
        num_errors++;
        wrap_up();
    end
endmodule
`default_nettype wire
